//--- inc/scm_map.vh
// Constants for the servo configuration-mode interface
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
`define SCM_NUM_WORDS 10
`define SCM_WORD_W 16
`define SCM_IMAGE_BYTES 20
`define SCM_WORD_CTRL 4'h0
`define SCM_WORD_SPARE 4'h1
`define SCM_WORD_PARAM_FIRST 4'h2
`define SCM_WORD_PARAM_LAST 4'h9
`define SCM_MB_BASE 16'h0400
`define SCM_MB_LAST 16'h0409
`define SCM_BIT_MODE 15
`define SCM_CMD_HI 11
`define SCM_CMD_LO 8
`define SCM_BLK_HI 3
`define SCM_BLK_LO 0
`define SCM_RSVD_MASK 16'h70F0
`define SCM_CMD_NOP0 4'h0
`define SCM_CMD_STATUS 4'h1
`define SCM_CMD_READ 4'h2
`define SCM_CMD_NOP8 4'h8
`define SCM_CMD_WRITE 4'hA
`define SCM_BLK_DATA 4'h1
`define SCM_BLK_FLASH 4'hF
`define SCM_BLK_MAX_VALID 4'h6
`define SCM_BLK_RSVD 4'h4
`define SCM_ENDIAN_BIT 0
`define SCM_RESP_OK 4'h0
`define SCM_RESP_CFG_ERR 4'h1
`define SCM_RESP_CMD_ERR 4'h2
`define SCM_RESP_BAD_WORD 4'h3
`endif

//--- rtl/scm_config_if.v
// Configuration-mode front end of a networked servo drive
`timescale 1ns/1ps
`include "scm_map.vh"

// What this block does
// - Bit 15 of output word 0 selects configuration (1) or command (0) mode.
// - In command mode with drive enabled, configuration is refused with command error.
// - Invalid configuration at power up forces configuration mode, reporting first bad parameter.
// - Configuration is loaded from flash first at power up as the default.
// - Network-supplied configuration at connection overrides the flash configuration if it comes before the first image update.
// - Valid configuration at power up starts the device in command mode.
// - In command mode, power stage enabled only while host enable bit set.
// - Written configuration lives in volatile storage until an explicit save command.
// - Cyclic image is twenty bytes each way, ten 16-bit words.
// - Default 32-bit order is low word first.
// - Data-endian parameter switches 32-bit values to high word first.
// - Word 0 is the control word; word 1 is reserved, written zero.
// - Words 2 to 9 carry parameters of the selected data block.
// - Output word n also reachable as holding register 1024 plus n.
// - Bits 11-8 hold the command number decoded into an operation.
// - Bits 3-0 select the configuration data block.
// - Command 2 reads, A writes; block F restores defaults or saves to flash.
// - Bit 0 of data configuration block selects word order.
module scm_config_if (
   input wire sys_clk, // 100 MHz system clock
   input wire rst_n, // Synchronous reset, active low
   input wire img_valid, // One-cycle pulse: whole output image updated
   input wire [159:0] img_words, // Ten output words, word 0 in bits 15:0
   input wire mb_wr, // Holding register write strobe
   input wire [15:0] mb_addr, // Holding register number
   input wire [15:0] mb_wdata, // Holding register write data
   input wire mb_commit, // Pulse: holding registers form a new image
   input wire flash_ready, // Pulse: flash image presented at power up
   input wire [127:0] flash_cfg, // Stored parameter words of data block
   input wire flash_valid, // Stored configuration passed its checks
   input wire net_cfg_stb, // Pulse: configuration from connection setup
   input wire [127:0] net_cfg, // Connection-setup parameter words
   input wire net_cfg_valid, // Connection configuration passed its checks
   input wire [3:0] bad_param, // Index of first parameter in error
   input wire drive_en_req, // Host drive-enable request bit
   input wire [31:0] pos_value, // Position value to report
   output reg cfg_mode_q, // 1 while in configuration mode
   output reg ready_q, // Power-up load done
   output reg motor_en_q, // Power stage enable
   output reg [3:0] resp_code_q, // Last response code
   output reg [3:0] err_param_q, // First parameter in error
   output reg [3:0] op_cmd_q, // Accepted command number
   output reg [3:0] op_blk_q, // Accepted block number
   output reg op_stb_q, // One-cycle pulse: command accepted
   output reg flash_save_q, // One-cycle pulse: save RAM to flash
   output reg defaults_q, // One-cycle pulse: restore factory defaults
   output reg big_endian_q, // Active word order
   output reg [15:0] pos_first_q, // First word of reported position
   output reg [15:0] pos_second_q, // Second word of reported position
   output reg [127:0] ram_cfg_q // Active parameter words in volatile store
);

   // ==========================================================
   // Modbus shadow of the output image
   reg [15:0] mb_img_q [0:`SCM_NUM_WORDS-1];
   reg [15:0] mb_idx;
   reg [159:0] mb_flat;
   integer i;
   integer k;

   always @* begin
      mb_idx = mb_addr - `SCM_MB_BASE;
      for (i = 0; i < `SCM_NUM_WORDS; i = i + 1) begin
         mb_flat[i*16 +: 16] = mb_img_q[i];
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         for (k = 0; k < `SCM_NUM_WORDS; k = k + 1) begin
            mb_img_q[k] <= 16'h0000;
         end
      end else if (mb_wr && mb_addr >= `SCM_MB_BASE && mb_addr <= `SCM_MB_LAST) begin
         mb_img_q[mb_idx[3:0]] <= mb_wdata;
      end
   end

   // ==========================================================
   // Image snapshot: the control word is taken whole on each update
   wire upd = img_valid | mb_commit;
   wire [159:0] src = img_valid ? img_words : mb_flat;
   wire [15:0] ctl = src[15:0];
   wire [15:0] spare = src[31:16];
   wire [127:0] params = src[159:32];
   wire [3:0] cmd = ctl[`SCM_CMD_HI:`SCM_CMD_LO];
   wire [3:0] blk = ctl[`SCM_BLK_HI:`SCM_BLK_LO];

   function cmd_legal;
      input [3:0] c;
      input [3:0] b;
      begin
         case (c)
            `SCM_CMD_NOP0, `SCM_CMD_NOP8, `SCM_CMD_STATUS: cmd_legal = (b == 4'h0);
            `SCM_CMD_READ, `SCM_CMD_WRITE: cmd_legal = (b == `SCM_BLK_FLASH) ||
               (b != 4'h0 && b != `SCM_BLK_RSVD && b <= `SCM_BLK_MAX_VALID);
            default: cmd_legal = 1'b0;
         endcase
      end
   endfunction

   wire word_ok = ((ctl & `SCM_RSVD_MASK) == 16'h0000) && (spare == 16'h0000);
   // A config word taken while the stage is off must keep the stage off in the same edge
   wire to_cfg = upd && ctl[`SCM_BIT_MODE] && !motor_en_q;

   // ==========================================================
   // Power-up sequencing and mode control
   localparam ST_WAIT_FLASH = 2'b00;
   localparam ST_WAIT_NET = 2'b01;
   localparam ST_RUN = 2'b10;
   reg [1:0] st_q;

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= ST_WAIT_FLASH;
         cfg_mode_q <= 1'b1;
         ready_q <= 1'b0;
         motor_en_q <= 1'b0;
         resp_code_q <= `SCM_RESP_OK;
         err_param_q <= 4'h0;
         op_cmd_q <= 4'h0;
         op_blk_q <= 4'h0;
         op_stb_q <= 1'b0;
         flash_save_q <= 1'b0;
         defaults_q <= 1'b0;
         big_endian_q <= 1'b0;
         ram_cfg_q <= 128'h0;
      end else begin
         op_stb_q <= 1'b0;
         flash_save_q <= 1'b0;
         defaults_q <= 1'b0;
         case (st_q)
            ST_WAIT_FLASH: begin
               if (flash_ready) begin
                  ram_cfg_q <= flash_cfg;
                  big_endian_q <= flash_cfg[`SCM_ENDIAN_BIT];
                  cfg_mode_q <= ~flash_valid;
                  err_param_q <= flash_valid ? 4'h0 : bad_param;
                  resp_code_q <= flash_valid ? `SCM_RESP_OK : `SCM_RESP_CFG_ERR;
                  ready_q <= 1'b1;
                  st_q <= ST_WAIT_NET;
               end
            end
            ST_WAIT_NET, ST_RUN: begin
               if (st_q == ST_WAIT_NET && net_cfg_stb) begin
                  ram_cfg_q <= net_cfg;
                  big_endian_q <= net_cfg[`SCM_ENDIAN_BIT];
                  cfg_mode_q <= ~net_cfg_valid;
                  err_param_q <= net_cfg_valid ? 4'h0 : bad_param;
                  resp_code_q <= net_cfg_valid ? `SCM_RESP_OK : `SCM_RESP_CFG_ERR;
                  st_q <= ST_RUN;
               end else if (upd) begin
                  st_q <= ST_RUN;
                  if (ctl[`SCM_BIT_MODE]) begin
                     // A config request while the drive runs is refused outright
                     if (motor_en_q) begin
                        resp_code_q <= `SCM_RESP_CMD_ERR;
                     end else if (!word_ok || !cmd_legal(cmd, blk)) begin
                        cfg_mode_q <= 1'b1;
                        resp_code_q <= `SCM_RESP_BAD_WORD;
                     end else begin
                        cfg_mode_q <= 1'b1;
                        resp_code_q <= `SCM_RESP_OK;
                        op_cmd_q <= cmd;
                        op_blk_q <= blk;
                        op_stb_q <= 1'b1;
                        if (cmd == `SCM_CMD_WRITE && blk == `SCM_BLK_FLASH) begin
                           flash_save_q <= 1'b1;
                        end else if (cmd == `SCM_CMD_READ && blk == `SCM_BLK_FLASH) begin
                           defaults_q <= 1'b1;
                        end else if (cmd == `SCM_CMD_WRITE) begin
                           ram_cfg_q <= params;
                           if (blk == `SCM_BLK_DATA) begin
                              big_endian_q <= params[`SCM_ENDIAN_BIT];
                           end
                        end
                     end
                  end else begin
                     cfg_mode_q <= 1'b0;
                  end
               end
               // Drive enable follows the request only in command mode
               motor_en_q <= (st_q == ST_RUN) && !cfg_mode_q && !to_cfg && drive_en_req;
            end
            default: st_q <= ST_WAIT_FLASH;
         endcase
      end
   end

   // ==========================================================
   // 32-bit word order of reported position
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pos_first_q <= 16'h0000;
         pos_second_q <= 16'h0000;
      end else if (big_endian_q) begin
         pos_first_q <= pos_value[31:16];
         pos_second_q <= pos_value[15:0];
      end else begin
         pos_first_q <= pos_value[15:0];
         pos_second_q <= pos_value[31:16];
      end
   end

endmodule

//--- verif/scm_chk.sv
// Assertions on the configuration-mode front end
`timescale 1ns/1ps
module scm_chk (
   input wire sys_clk, // Clock
   input wire rst_n, // Reset, active low
   input wire img_valid, // Image strobe
   input wire [159:0] img_words, // Image
   input wire drive_en_req, // Enable request
   input wire [31:0] pos_value, // Position
   input wire ready_q, // Load done
   input wire cfg_mode_q, // Mode
   input wire motor_en_q, // Power stage
   input wire [3:0] resp_code_q, // Response
   input wire op_stb_q, // Accept pulse
   input wire [3:0] op_cmd_q, // Command
   input wire flash_save_q, // Save pulse
   input wire defaults_q, // Defaults pulse
   input wire big_endian_q, // Word order
   input wire [15:0] pos_first_q, // First word
   input wire [15:0] pos_second_q // Second word
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire [15:0] w0 = img_words[15:0];
   wire tk = img_valid && ready_q && !motor_en_q;
   property p_refuse;
      img_valid && ready_q && motor_en_q && w0[15] |=> resp_code_q == 4'h2 && !op_stb_q && !cfg_mode_q;
   endproperty
   a_refuse: assert property (p_refuse) else $error("config taken while drive enabled");
   property p_rsvd;
      tk && (w0 & 16'h70F0) != 16'h0000 |=> resp_code_q == 4'h3 && cfg_mode_q && !op_stb_q;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not refused");
   property p_write;
      tk && w0 == 16'h8A01 |=> cfg_mode_q && op_stb_q && op_cmd_q == 4'hA ##1 !op_stb_q;
   endproperty
   a_write: assert property (p_write) else $error("write command not accepted");
   property p_cmd;
      tk && w0 == 16'h0000 |=> !cfg_mode_q;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command mode not entered");
   property p_motor;
      motor_en_q |-> !cfg_mode_q && $past(drive_en_req);
   endproperty
   a_motor: assert property (p_motor) else $error("power stage on without request");
   property p_save;
      tk && w0 == 16'h8A0F |=> flash_save_q && !defaults_q ##1 !flash_save_q;
   endproperty
   a_save: assert property (p_save) else $error("save pulse wrong");
   property p_dflt;
      tk && w0 == 16'h820F |=> defaults_q && !flash_save_q;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults pulse wrong");
   property p_order;
      $past(rst_n) && $stable(big_endian_q) && big_endian_q == $past(big_endian_q, 2) |->
         {pos_first_q, pos_second_q} == (big_endian_q ? pos_value : {pos_value[15:0], pos_value[31:16]});
   endproperty
   a_order: assert property (p_order) else $error("position word order wrong");
   property p_ignore;
      img_valid && !ready_q |=> !op_stb_q && !flash_save_q;
   endproperty
   a_ignore: assert property (p_ignore) else $error("image acted on before load");
   cover property (tk && w0 == 16'h8A01);
   cover property ($rose(motor_en_q));
   cover property (img_valid && motor_en_q && w0[15]);
endmodule
bind scm_config_if scm_chk u_chk (.*);

//--- verif/scm_host.sv
// Host model that writes whole output images
`timescale 1ns/1ps
module scm_host (
   input wire sys_clk, // Clock
   input wire go, // Send one image
   input wire [15:0] w0, // Control word
   input wire [127:0] prm, // Parameter words
   output reg img_valid, // Image strobe
   output reg [159:0] img_words // Ten output words
);
   initial begin
      img_valid = 1'b0;
      img_words = 160'h0;
   end
   always @(posedge sys_clk) begin
      img_valid <= go;
      // Idle words keep changing so a stale image never looks valid
      img_words <= go ? {prm, 16'h0000, w0} : ~img_words;
   end
endmodule

//--- verif/tb.sv
// Self-checking bench for the configuration-mode front end
`timescale 1ns/1ps
module tb;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   reg go, mb_wr, mb_commit, flash_ready, flash_valid, net_cfg_stb, net_cfg_valid, drive_en_req;
   reg [15:0] w0, mb_addr, mb_wdata;
   reg [127:0] prm, flash_cfg, net_cfg;
   reg [3:0] bad_param;
   reg [31:0] pos_value;
   wire img_valid, cfg_mode_q, ready_q, motor_en_q, op_stb_q, flash_save_q, defaults_q, big_endian_q;
   wire [159:0] img_words;
   wire [3:0] resp_code_q, err_param_q, op_cmd_q, op_blk_q;
   wire [15:0] pos_first_q, pos_second_q;
   wire [127:0] ram_cfg_q;
   integer n_fail = 0, comparisons = 0, i;
   always #5 sys_clk = ~sys_clk;
   scm_host u_host (.sys_clk(sys_clk), .go(go), .w0(w0), .prm(prm), .img_valid(img_valid), .img_words(img_words));
   scm_config_if u_dut (.*);
   // ==========================================
   // Tasks
   task chk(input [127:0] seen, input [127:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task send(input [15:0] w, input [127:0] p);
      @(posedge sys_clk) begin go <= 1'b1; w0 <= w; prm <= p; end
      @(posedge sys_clk) go <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   // An image before the flash load must be ignored
   task boot(input ok, input [3:0] bp);
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      send(16'h8A01, {8{16'h3331}});
      @(posedge sys_clk) begin flash_valid <= ok; bad_param <= bp; flash_ready <= 1'b1; end
      @(posedge sys_clk) flash_ready <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {go, mb_wr, mb_commit, flash_ready, flash_valid, net_cfg_stb, net_cfg_valid, drive_en_req} = 8'h00;
      w0 = 16'h0000; mb_addr = 16'h0000; mb_wdata = 16'h0000; prm = 128'h0; bad_param = 4'h0;
      pos_value = 32'hFFFF_FFF4; flash_cfg = {8{16'h1110}}; net_cfg = {8{16'h2220}};
      boot(1'b0, 4'h5);
      chk(cfg_mode_q, 1'b1);
      chk(err_param_q, 4'h5);
      boot(1'b1, 4'h0);
      chk(cfg_mode_q, 1'b0);
      chk(ram_cfg_q, flash_cfg);
      @(posedge sys_clk) begin net_cfg_valid <= 1'b1; net_cfg_stb <= 1'b1; end
      @(posedge sys_clk) net_cfg_stb <= 1'b0;
      @(posedge sys_clk);
      #1 chk(ram_cfg_q, net_cfg);
      @(posedge sys_clk) drive_en_req <= 1'b1;
      send(16'h0000, 128'h0);
      @(posedge sys_clk);
      #1 chk(motor_en_q, 1'b1);
      send(16'h8A01, {8{16'h4441}});
      chk(resp_code_q, 4'h2);
      chk(ram_cfg_q, net_cfg);
      @(posedge sys_clk) drive_en_req <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk(motor_en_q, 1'b0);
      send(16'h8A01, {8{16'h4441}});
      chk(ram_cfg_q, {8{16'h4441}});
      chk(big_endian_q, 1'b1);
      @(posedge sys_clk);
      #1 chk({pos_first_q, pos_second_q}, 32'hFFFF_FFF4);
      send(16'h8A01, {8{16'h5550}});
      @(posedge sys_clk);
      #1 chk({pos_first_q, pos_second_q}, 32'hFFF4_FFFF);
      send(16'h8A0F, 128'h0);
      chk(flash_save_q, 1'b1);
      send(16'h820F, 128'h0);
      chk(defaults_q, 1'b1);
      for (i = 0; i < 16; i = i + 1) begin
         send({4'h8, i[3:0], 8'h01}, 128'h0);
         chk(resp_code_q, (i == 2 || i == 10) ? 4'h0 : 4'h3);
      end
      for (i = 0; i < 7; i = i + 1) begin
         send(16'h8A01 | (16'h0001 << (i < 4 ? i + 4 : i + 8)), 128'h0);
         chk(resp_code_q, 4'h3);
      end
      for (i = 0; i < 11; i = i + 1) begin
         @(posedge sys_clk) begin mb_wr <= 1'b1; mb_addr <= 16'h0400 + i[15:0]; end
         mb_wdata <= (i == 0) ? 16'h8A01 : (i == 1) ? 16'h0000 : (i == 10) ? 16'hFFFF : 16'h6660;
      end
      @(posedge sys_clk) begin mb_wr <= 1'b0; mb_commit <= 1'b1; end
      @(posedge sys_clk) mb_commit <= 1'b0;
      @(posedge sys_clk);
      #1 chk(ram_cfg_q, {8{16'h6660}});
      tally_and_finish;
   end
   initial begin
      #200000;
      n_fail = n_fail + 1;
      tally_and_finish;
   end
endmodule
